/* ssi_top.sv */
// safety-state supervisor: indicators, ack handshake, apb registers
//
// Decided for this implementation: the APB register port and the register addresses.
`include "ssi_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ssi_top #(
   parameter int unsigned ON_CYC =
      `SSI_FLASH_ON_MS * (`SSI_CLK_HZ / 1000),
   parameter int unsigned PAUSE_CYC =
      `SSI_FLASH_PAUSE_MS * (`SSI_CLK_HZ / 1000),
   parameter int unsigned OV_CYC =
      `SSI_OVERVOLT_MS * (`SSI_CLK_HZ / 1000)
) (
   input  wire logic                   I_CLK_SYS,
   input  wire logic                   I_RSTN,
   input  wire logic [`SSI_ADDR_W-1:0] I_PADDR,
   input  wire logic                   I_PSEL,
   input  wire logic                   I_PENABLE,
   input  wire logic                   I_PWRITE,
   input  wire logic [31:0]            I_PWDATA,
   output logic      [31:0]            O_PRDATA,
   output logic                        O_PREADY,
   output logic                        O_PSLVERR,
   input  wire logic                   I_INIT_DONE,
   input  wire logic                   I_INIT_BLOCKED,
   input  wire logic                   I_COMM_LOST,
   input  wire logic                   I_COMM_ERR,
   input  wire logic                   I_WINDOW_ERR,
   input  wire logic                   I_TEMP_ERR,
   input  wire logic                   I_OVERVOLT,
   input  wire logic                   I_OVERSPEED,
   output logic                        O_LED_GREEN,
   output logic                        O_LED_RED,
   output logic                        O_SAFE_STATE,
   output logic                        O_ACK_REQ,
   output logic                        O_PASSIVATE,
   output logic                        O_SHUTDOWN,
   output logic                        O_IRQ
);
   // positions of the pin inputs inside the synchroniser vectors
   localparam int S_INIT_DONE = 0;
   localparam int S_INIT_BLK  = 1;
   localparam int S_COMM_LOST = 2;
   localparam int S_COMM_ERR  = 3;
   localparam int S_WIN_ERR   = 4;
   localparam int S_TEMP_ERR  = 5;
   localparam int S_OVERVOLT  = 6;
   localparam int S_OVERSPEED = 7;

   ssi_pkg::ssi_top_s q;
   ssi_pkg::ssi_top_s n;

   logic       flash1;
   logic       flash2;
   logic       ov_hit;
   logic [7:0] pins;
   logic       setup;
   logic       wr;
   logic       ack_rise;
   logic       fault_now;
   logic       latched;
   logic [3:0] irq_ev;
   logic [3:0] irq_clr;

   ssi_flash #(
      .N_PULSE   (1),
      .ON_CYC    (ON_CYC),
      .PAUSE_CYC (PAUSE_CYC)
   ) u_flash1 (
      .i_clk  (I_CLK_SYS),
      .i_rstn (I_RSTN),
      .o_led  (flash1)
   );

   ssi_flash #(
      .N_PULSE   (2),
      .ON_CYC    (ON_CYC),
      .PAUSE_CYC (PAUSE_CYC)
   ) u_flash2 (
      .i_clk  (I_CLK_SYS),
      .i_rstn (I_RSTN),
      .o_led  (flash2)
   );

   ssi_persist #(
      .LIMIT (OV_CYC)
   ) u_overvolt (
      .i_clk   (I_CLK_SYS),
      .i_rstn  (I_RSTN),
      .i_level (q.sync2[S_OVERVOLT]),
      .o_hit   (ov_hit)
   );

   assign pins = {I_OVERSPEED, I_OVERVOLT, I_TEMP_ERR, I_WINDOW_ERR,
                  I_COMM_ERR, I_COMM_LOST, I_INIT_BLOCKED, I_INIT_DONE};
   assign setup = I_PSEL & ~I_PENABLE;
   // the write lands at the edge where the master sees pready high
   assign wr = I_PSEL & I_PENABLE & I_PWRITE & q.pready;
   assign ack_rise = q.ctrl[`SSI_CTRL_ACK_BIT] & ~q.ack_prev;
   assign latched = q.ovl_lat | q.spd_lat;
   // brief overvoltage is tolerated; only the persisted level counts
   assign fault_now = q.sync2[S_COMM_ERR] | q.sync2[S_WIN_ERR]
                    | q.sync2[S_TEMP_ERR] | q.sync2[S_OVERSPEED]
                    | ov_hit | latched;

   always_comb begin
      n = q;
      irq_ev  = 4'h0;
      irq_clr = 4'h0;
      n.sync1 = pins;
      n.sync2 = q.sync1;
      n.ack_prev = q.ctrl[`SSI_CTRL_ACK_BIT];

      // latches survive everything except reset, i.e. a power cycle
      if (ov_hit) begin
         n.ovl_lat = 1'b1;
      end
      if (q.dual && q.sync2[S_OVERSPEED]) begin
         n.spd_lat = 1'b1;
      end

      case (q.st)
         ssi_pkg::ST_INIT: begin
            if (fault_now) begin
               n.st = ssi_pkg::ST_FAULT;
            end else if (q.sync2[S_INIT_DONE]) begin
               n.st = ssi_pkg::ST_OPER;
            end else if (q.sync2[S_INIT_BLK]) begin
               n.st = ssi_pkg::ST_INIT_STUCK;
            end
         end
         ssi_pkg::ST_INIT_STUCK: begin
            if (fault_now) begin
               n.st = ssi_pkg::ST_FAULT;
            end else if (q.sync2[S_INIT_DONE]) begin
               n.st = ssi_pkg::ST_OPER;
            end else if (!q.sync2[S_INIT_BLK]) begin
               n.st = ssi_pkg::ST_INIT;
            end
         end
         ssi_pkg::ST_OPER: begin
            if (fault_now) begin
               n.st = ssi_pkg::ST_FAULT;
            end else if (q.sync2[S_COMM_LOST]) begin
               n.st = ssi_pkg::ST_SUBST;
            end
         end
         ssi_pkg::ST_SUBST: begin
            // substitute data holds until the link is back and acked
            if (fault_now) begin
               n.st = ssi_pkg::ST_FAULT;
            end else if (!q.sync2[S_COMM_LOST] && ack_rise) begin
               n.st = ssi_pkg::ST_OPER;
            end
         end
         ssi_pkg::ST_FAULT: begin
            if (!fault_now) begin
               n.st = ssi_pkg::ST_AWAIT_ACK;
            end
         end
         ssi_pkg::ST_AWAIT_ACK: begin
            if (fault_now) begin
               n.st = ssi_pkg::ST_FAULT;
            end else if (ack_rise) begin
               n.st = ssi_pkg::ST_OPER;
            end
         end
         default: begin
            n.st = ssi_pkg::ST_FAULT;
         end
      endcase

      // outputs follow the next state so they line up with q.st
      n.safe    = (n.st == ssi_pkg::ST_OPER);
      n.ack_req = (n.st == ssi_pkg::ST_AWAIT_ACK);
      n.passiv  = (n.st != ssi_pkg::ST_OPER)
                & (n.st != ssi_pkg::ST_AWAIT_ACK);
      n.shutdown = n.ovl_lat;
      n.led_r = 1'b0;
      n.led_g = 1'b0;
      case (n.st)
         ssi_pkg::ST_INIT_STUCK: n.led_g = flash1;
         ssi_pkg::ST_SUBST:      n.led_g = flash2;
         ssi_pkg::ST_OPER:       n.led_g = 1'b1;
         ssi_pkg::ST_FAULT:      n.led_r = 1'b1;
         ssi_pkg::ST_AWAIT_ACK:  n.led_r = flash1;
         default:                n.led_g = 1'b0;
      endcase

      if (n.st == ssi_pkg::ST_FAULT && q.st != ssi_pkg::ST_FAULT) begin
         irq_ev[`SSI_IRQ_FAULT] = 1'b1;
      end
      if (n.st == ssi_pkg::ST_AWAIT_ACK && q.st != ssi_pkg::ST_AWAIT_ACK)
      begin
         irq_ev[`SSI_IRQ_ACKREQ] = 1'b1;
      end
      if (n.st == ssi_pkg::ST_OPER && q.st != ssi_pkg::ST_OPER) begin
         irq_ev[`SSI_IRQ_SAFE] = 1'b1;
      end
      if ((n.ovl_lat & ~q.ovl_lat) | (n.spd_lat & ~q.spd_lat)) begin
         irq_ev[`SSI_IRQ_LATCH] = 1'b1;
      end

      // register writes
      if (wr) begin
         if (I_PADDR == `SSI_OFF_CTRL) begin
            n.ctrl = I_PWDATA[15:0];
         end else if (I_PADDR == `SSI_OFF_IRQ_STAT) begin
            irq_clr = I_PWDATA[3:0];
         end else if (I_PADDR == `SSI_OFF_IRQ_MASK) begin
            n.irq_mask = I_PWDATA[3:0];
         end else if (I_PADDR == `SSI_OFF_CFG) begin
            n.dual = I_PWDATA[`SSI_CFG_DUAL_BIT];
         end
      end
      // a new event wins over a clear in the same cycle
      n.irq_stat = (q.irq_stat & ~irq_clr) | irq_ev;
      n.irq = |(n.irq_stat & n.irq_mask);

      // read data is captured in the setup cycle, answered next cycle
      n.pready  = setup;
      n.pslverr = 1'b0;
      n.prdata  = 32'h0;
      if (setup) begin
         if (I_PADDR == `SSI_OFF_CTRL) begin
            n.prdata = {16'h0, q.ctrl};
         end else if (I_PADDR == `SSI_OFF_STATUS) begin
            n.prdata = {23'h0, q.st, q.dual, q.shutdown, q.passiv,
                        q.ack_req, q.safe, 1'b0};
         end else if (I_PADDR == `SSI_OFF_IRQ_STAT) begin
            n.prdata = {28'h0, q.irq_stat};
         end else if (I_PADDR == `SSI_OFF_IRQ_MASK) begin
            n.prdata = {28'h0, q.irq_mask};
         end else if (I_PADDR == `SSI_OFF_CFG) begin
            n.prdata = {31'h0, q.dual};
         end else begin
            n.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         q <= '0;
         q.ctrl <= `SSI_CTRL_RESET;
         q.dual <= `SSI_CFG_RESET;
         q.irq_mask <= `SSI_IRQ_MASK_RESET;
         q.passiv <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign O_PRDATA     = q.prdata;
   assign O_PREADY     = q.pready;
   assign O_PSLVERR    = q.pslverr;
   assign O_LED_GREEN  = q.led_g;
   assign O_LED_RED    = q.led_r;
   assign O_SAFE_STATE = q.safe;
   assign O_ACK_REQ    = q.ack_req;
   assign O_PASSIVATE  = q.passiv;
   assign O_SHUTDOWN   = q.shutdown;
   assign O_IRQ        = q.irq;

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RSTN);

   sequence s_awaiting;
      q.st == ssi_pkg::ST_AWAIT_ACK && !fault_now;
   endsequence
   sequence s_acked;
      s_awaiting ##0 ack_rise;
   endsequence

   a_green_dark_init: assert property (
      q.st == ssi_pkg::ST_INIT |-> !O_LED_GREEN && !O_SAFE_STATE)
      else $error("green lit or safe during init");
   a_stuck_green_flash: assert property (
      q.st == ssi_pkg::ST_INIT_STUCK ##1 q.st == ssi_pkg::ST_INIT_STUCK
      |-> O_LED_GREEN == $past(flash1))
      else $error("stuck init does not single-flash green");
   a_oper_green_safe: assert property (
      q.st == ssi_pkg::ST_OPER |-> O_LED_GREEN && O_SAFE_STATE && !O_LED_RED)
      else $error("operational state without steady green and safe");
   a_await_flags: assert property (
      q.st == ssi_pkg::ST_AWAIT_ACK
      |-> O_ACK_REQ && !O_SAFE_STATE && !O_LED_GREEN)
      else $error("awaiting ack with wrong flags");
   a_fault_red: assert property (
      q.st == ssi_pkg::ST_FAULT
      |-> O_LED_RED && !O_LED_GREEN && O_PASSIVATE && !O_SAFE_STATE)
      else $error("fault state without steady red and passivation");
   a_ovl_sticky: assert property (
      q.ovl_lat |=> q.ovl_lat && O_SHUTDOWN && q.st == ssi_pkg::ST_FAULT)
      else $error("overvoltage latch released or not in fault");
   a_safe_only_ack: assert property (
      q.st == ssi_pkg::ST_AWAIT_ACK && !ack_rise |=> !O_SAFE_STATE)
      else $error("safe-state returned without acknowledgement");
   a_speed_latch: assert property (
      q.dual && q.sync2[S_OVERSPEED] |=> q.spd_lat [*2])
      else $error("dual-scan overspeed not latched");
   a_fault_enter: assert property (
      q.st == ssi_pkg::ST_OPER && fault_now
      |=> q.st == ssi_pkg::ST_FAULT && O_PASSIVATE)
      else $error("fault did not switch to substitute data");
   a_restart_req: assert property (
      q.st == ssi_pkg::ST_FAULT && !fault_now
      |=> O_ACK_REQ && !O_SAFE_STATE && !O_PASSIVATE)
      else $error("cleared fault did not request acknowledgement");
   a_ack_restore: assert property (
      s_acked |=> O_SAFE_STATE && !O_ACK_REQ && $fell(O_ACK_REQ))
      else $error("ack edge did not restore safe-state");
   a_ack_edge_only: assert property (
      s_awaiting and (q.ctrl[`SSI_CTRL_ACK_BIT] && q.ack_prev)
      |=> q.st == ssi_pkg::ST_AWAIT_ACK)
      else $error("held ack bit accepted as new acknowledgement");

endmodule : ssi_top
`default_nettype wire

/* ssi_params.svh */
// constants for the safety-state indicator and acknowledgement block
// What this block does
// - green stays dark while the safety channel initialises or is off.
// - green single-flashes while initialisation cannot complete.
// - green double-flashes while substitute data is output after a link loss.
// - in normal operation green is steady and the safe-state flag is 1.
// - awaiting acknowledgement, red single-flashes, green is dark, flags 1/0.
// - bit 6 of the safety control word is the fault acknowledge from the master.
// - a safety fault gives passivated data, steady red and dark green.
// - supply above 36 V for longer than 200 ms latches a shutdown fault.
// - after a fault the safe-state flag returns only by ack or power cycle.
// - in the dual scanning variant overspeed clears only by power cycle.
// - a detected fault switches process output to substitute data at once.
// - once a restartable fault is gone, data resumes, safe 0 and request 1.
// - the acknowledgement sets the safe-state flag back to 1.
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH

`define SSI_CLK_HZ        100000000
`define SSI_FLASH_ON_MS   200
`define SSI_FLASH_PAUSE_MS 1000
`define SSI_OVERVOLT_MS   200

`define SSI_ADDR_W        12
`define SSI_OFF_CTRL      12'h000
`define SSI_OFF_STATUS    12'h004
`define SSI_OFF_IRQ_STAT  12'h008
`define SSI_OFF_IRQ_MASK  12'h00c
`define SSI_OFF_CFG       12'h010

`define SSI_CTRL_ACK_BIT  6
`define SSI_CTRL_RESET    16'h0000
`define SSI_CFG_DUAL_BIT  0
`define SSI_CFG_RESET     1'h0
`define SSI_IRQ_MASK_RESET 4'h0

`define SSI_IRQ_FAULT     0
`define SSI_IRQ_ACKREQ    1
`define SSI_IRQ_SAFE      2
`define SSI_IRQ_LATCH     3

`endif

/* ssi_pkg.sv */
// types shared by the safety-state indicator modules
package ssi_pkg;

   typedef enum logic [2:0] {
      ST_INIT,
      ST_INIT_STUCK,
      ST_SUBST,
      ST_OPER,
      ST_FAULT,
      ST_AWAIT_ACK
   } ssi_state_e;

   typedef struct packed {
      logic [31:0] cnt;
      logic [1:0]  idx;
      logic        on;
   } ssi_flash_s;

   typedef struct packed {
      logic [31:0] cnt;
      logic        hit;
   } ssi_persist_s;

   typedef struct packed {
      ssi_state_e  st;
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic [15:0] ctrl;
      logic        dual;
      logic        ack_prev;
      logic        ovl_lat;
      logic        spd_lat;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        led_g;
      logic        led_r;
      logic        safe;
      logic        ack_req;
      logic        passiv;
      logic        shutdown;
      logic        irq;
   } ssi_top_s;

endpackage : ssi_pkg

/* ssi_flash.sv */
// repeating flash pattern of N pulses followed by a long dark pause
`timescale 1ns/1ps
`default_nettype none
module ssi_flash #(
   parameter int unsigned N_PULSE   = 1,
   parameter int unsigned ON_CYC    = 20000000,
   parameter int unsigned PAUSE_CYC = 100000000
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   output logic      o_led
);
   ssi_pkg::ssi_flash_s q;
   ssi_pkg::ssi_flash_s n;

   always_comb begin
      n = q;
      if (q.cnt != 32'h0) begin
         n.cnt = q.cnt - 32'h1;
      end else if (!q.on) begin
         n.on  = 1'b1;
         n.cnt = 32'(ON_CYC - 1);
      end else begin
         n.on = 1'b0;
         // gap between pulses equals the pulse, the last one gets the pause
         if (q.idx == 2'(N_PULSE - 1)) begin
            n.idx = 2'h0;
            n.cnt = 32'(PAUSE_CYC - 1);
         end else begin
            n.idx = q.idx + 2'h1;
            n.cnt = 32'(ON_CYC - 1);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign o_led = q.on;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_flash_on_len: assert property (
      $rose(q.on) |-> q.cnt == 32'(ON_CYC - 1))
      else $error("flash pulse loaded with wrong length");
   a_flash_pause: assert property (
      $fell(q.on) && q.idx == 2'h0 |-> q.cnt == 32'(PAUSE_CYC - 1))
      else $error("flash pause loaded with wrong length");

endmodule : ssi_flash
`default_nettype wire

/* ssi_persist.sv */
// flags a level that has stayed high for more than LIMIT cycles
`timescale 1ns/1ps
`default_nettype none
module ssi_persist #(
   parameter int unsigned LIMIT = 20000000
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_level,
   output logic      o_hit
);
   ssi_pkg::ssi_persist_s q;
   ssi_pkg::ssi_persist_s n;

   always_comb begin
      n = q;
      if (!i_level) begin
         n.cnt = 32'h0;
         n.hit = 1'b0;
      end else if (q.cnt == 32'(LIMIT)) begin
         n.hit = 1'b1;
      end else begin
         n.cnt = q.cnt + 32'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign o_hit = q.hit;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_persist_hit: assert property (
      $rose(q.hit) |-> $past(i_level) && q.cnt == 32'(LIMIT))
      else $error("overvoltage flagged before its persistence time");

endmodule : ssi_persist
`default_nettype wire

/* ssi_far_model.sv */
// behavioural far side: safety master link state and fault sources
`timescale 1ns/1ps
`default_nettype none
module ssi_far_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_set,
   output logic            o_init_done,
   output logic            o_init_blocked,
   output logic            o_comm_lost,
   output logic            o_comm_err,
   output logic            o_window_err,
   output logic            o_temp_err,
   output logic            o_overvolt,
   output logic            o_overspeed
);
   // levels change only just after an edge, as a real link would report
   always_ff @(posedge i_clk) begin
      o_init_done    <= i_set[0];
      o_init_blocked <= i_set[1];
      o_comm_lost    <= i_set[2];
      o_comm_err     <= i_set[3];
      o_window_err   <= i_set[4];
      o_temp_err     <= i_set[5];
      o_overvolt     <= i_set[6];
      o_overspeed    <= i_set[7];
   end
endmodule : ssi_far_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the safety-state supervisor
`include "ssi_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned ON  = 4;
   localparam int unsigned PAU = 10;
   localparam int unsigned OV  = 8;
   logic        clk;
   logic        rstn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  cond;
   wire  logic [7:0] lv;
   wire  logic [6:0] outs;
   int          n_errors;
   int          comparisons;
   int          fb[4] = '{3, 4, 5, 7};

   ssi_far_model i_ssi_far_model (.i_clk(clk), .i_set(cond),
      .o_init_done(lv[0]), .o_init_blocked(lv[1]), .o_comm_lost(lv[2]),
      .o_comm_err(lv[3]), .o_window_err(lv[4]), .o_temp_err(lv[5]),
      .o_overvolt(lv[6]), .o_overspeed(lv[7]));

   ssi_top #(.ON_CYC(ON), .PAUSE_CYC(PAU), .OV_CYC(OV)) i_ssi_top (
      .I_CLK_SYS(clk), .I_RSTN(rstn), .I_PADDR(paddr), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_INIT_DONE(lv[0]), .I_INIT_BLOCKED(lv[1]), .I_COMM_LOST(lv[2]),
      .I_COMM_ERR(lv[3]), .I_WINDOW_ERR(lv[4]), .I_TEMP_ERR(lv[5]),
      .I_OVERVOLT(lv[6]), .I_OVERSPEED(lv[7]),
      .O_LED_GREEN(outs[0]), .O_LED_RED(outs[1]), .O_SAFE_STATE(outs[2]),
      .O_ACK_REQ(outs[3]), .O_PASSIVATE(outs[4]), .O_SHUTDOWN(outs[5]),
      .O_IRQ(outs[6]));

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic hang(input string what);
      n_errors++;
      $display("BAD %s expected response seen none", what);
      report_and_stop();
   endtask : hang

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) hang("apb ready");
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk("write error flag", 32'h0, {31'h0, err});
   endtask : wr

   task automatic rdchk(input string what, input logic [11:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(what, exp, rd & m);
   endtask : rdchk

   task automatic wait_state(input logic [2:0] exp);
      logic [31:0] rd;
      logic        err;
      int          n;
      n = 0;
      do begin
         apb(1'b0, `SSI_OFF_STATUS, 32'h0, rd, err);
         n++;
      end while (rd[8:6] !== exp && n < 12);
      if (n >= 12) hang("state");
      chk("state field", {29'h0, exp}, {29'h0, rd[8:6]});
   endtask : wait_state

   task automatic wait_outs(input string what, input logic [6:0] m,
                            input logic [6:0] v);
      int n;
      n = 0;
      while ((outs & m) !== v && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) hang(what);
      chk(what, {25'h0, v}, {25'h0, outs & m});
   endtask : wait_outs

   // counts lit cycles and pulses over whole pattern periods
   task automatic flash(input string what, input int sel, input int win,
                        input int hi, input int rise);
      int   h;
      int   r;
      logic p;
      h = 0;
      r = 0;
      @(posedge clk);
      p = outs[sel];
      repeat (win) begin
         @(posedge clk);
         if (outs[sel] === 1'b1) h++;
         if (outs[sel] === 1'b1 && p === 1'b0) r++;
         p = outs[sel];
      end
      chk({what, " lit cycles"}, hi, h);
      chk({what, " pulses"}, rise, r);
   endtask : flash

   task automatic ack;
      wr(`SSI_OFF_CTRL, 32'h0);
      wr(`SSI_OFF_CTRL, 32'h40);
   endtask : ack

   // the request must drop in the very cycle the safe flag rises;
   // req says whether a request was pending (substitute data has none)
   task automatic ack_chk(input logic req);
      int n;
      ack();
      for (n = 0; n < 6; n++) begin
         @(posedge clk);
         chk("request vs safe", {31'h0, req & ~outs[2]},
             {31'h0, outs[3]});
      end
      wait_outs("acknowledged", 7'h7f, 7'h05);
   endtask : ack_chk

   task automatic do_reset;
      rstn <= 1'b0;
      cond <= 8'h00;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      wait_outs("after reset", 7'h6f, 7'h00);
   endtask : do_reset

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      hang("run length");
   end

   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cond = 8'h00;
      n_errors = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rdchk("ctrl reset", `SSI_OFF_CTRL, 32'hffffffff, 32'h0);
      rdchk("mask reset", `SSI_OFF_IRQ_MASK, 32'hffffffff, 32'h0);
      rdchk("cfg reset", `SSI_OFF_CFG, 32'hffffffff, 32'h0);
      wr(`SSI_OFF_CTRL, 32'hffffffbf);
      rdchk("ctrl width", `SSI_OFF_CTRL, 32'hffffffff, 32'h0000ffbf);
      wr(`SSI_OFF_CTRL, 32'h0);
      wr(`SSI_OFF_IRQ_MASK, 32'hffffffff);
      rdchk("mask width", `SSI_OFF_IRQ_MASK, 32'hffffffff, 32'h0000000f);
      // masked again so state events do not raise the interrupt yet
      wr(`SSI_OFF_IRQ_MASK, 32'h0);
      begin : unmapped
         logic [31:0] rd;
         logic        err;
         apb(1'b0, 12'h014, 32'h0, rd, err);
         chk("unmapped error", 32'h1, {31'h0, err});
         chk("unmapped data", 32'h0, rd);
      end
      wait_state(3'h0);
      wait_outs("init dark", 7'h0d, 7'h00);
      $display("test registers and init done");
      cond <= 8'h02;
      wait_state(3'h1);
      flash("single green", 0, 3 * (ON + PAU), 3 * ON, 3);
      cond <= 8'h00;
      wait_state(3'h0);
      cond <= 8'h01;
      wait_state(3'h3);
      wait_outs("operational", 7'h3f, 7'h05);
      cond <= 8'h05;
      wait_state(3'h2);
      wait_outs("substitute", 7'h36, 7'h10);
      flash("double green", 0, 2 * (3 * ON + PAU), 4 * ON, 4);
      cond <= 8'h01;
      ack_chk(1'b0);
      $display("test indicator states done");
      wr(`SSI_OFF_IRQ_MASK, 32'h1);
      foreach (fb[i]) begin
         cond <= 8'h01 | (8'h01 << fb[i]);
         wait_outs("fault", 7'h7f, 7'h52);
         wr(`SSI_OFF_IRQ_MASK, 32'h0);
         wait_outs("irq masked", 7'h40, 7'h00);
         wr(`SSI_OFF_IRQ_MASK, 32'h1);
         wait_outs("irq unmasked", 7'h40, 7'h40);
         wr(`SSI_OFF_IRQ_STAT, 32'hf);
         wait_outs("irq cleared", 7'h40, 7'h00);
         ack();
         cond <= 8'h01;
         wait_outs("await ack", 7'h7d, 7'h08);
         flash("single red", 1, 3 * (ON + PAU), 3 * ON, 3);
         ack_chk(1'b1);
      end
      $display("test acknowledgeable faults done");
      cond <= 8'h41;
      repeat (OV / 2) @(posedge clk);
      cond <= 8'h01;
      repeat (20) @(posedge clk);
      wait_outs("short surge", 7'h3f, 7'h05);
      cond <= 8'h41;
      wait_outs("surge latch", 7'h3f, 7'h32);
      rdchk("irq events", `SSI_OFF_IRQ_STAT, 32'hf, 32'hf);
      cond <= 8'h01;
      ack();
      repeat (20) @(posedge clk);
      wait_outs("latch holds", 7'h3f, 7'h32);
      do_reset();
      wr(`SSI_OFF_CFG, 32'h1);
      rdchk("dual flag", `SSI_OFF_STATUS, 32'h20, 32'h20);
      cond <= 8'h01;
      wait_state(3'h3);
      cond <= 8'h81;
      wait_outs("overspeed", 7'h3f, 7'h12);
      cond <= 8'h01;
      ack();
      repeat (20) @(posedge clk);
      wait_outs("overspeed holds", 7'h3f, 7'h12);
      do_reset();
      rdchk("cfg after reset", `SSI_OFF_CFG, 32'hffffffff, 32'h0);
      $display("test latched faults done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
